/* File: inc/pea_pkg.sv */
`default_nettype none

package pea_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int REG_W = 64;
    localparam logic [ADDR_W-1:0] AFF_OFFSET = 12'h0fa8;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int FIELD_W = 8;
    localparam int NUM_LOW_FIELDS = 3;
    localparam int AFFINITY_LEVEL_ZERO_FIELD_LSB = 0;
    localparam int AFFINITY_LEVEL_ONE_FIELD_LSB = 8;
    localparam int AFFINITY_LEVEL_TWO_FIELD_LSB = 16;
    localparam int MT_BIT = 24;
    localparam int RSVD_LO_LSB = 25;
    localparam int RSVD_LO_W = 5;
    localparam int U_BIT = 30;
    localparam int F0V_BIT = 31;
    localparam int AFFINITY_LEVEL_THREE_FIELD_LSB = 32;
    localparam int RSVD_HI_LSB = 40;
    localparam int RSVD_HI_W = 24;

    // ------------------------------------------------------------------
    // Field values and limits
    // ------------------------------------------------------------------
    localparam logic [FIELD_W-1:0] FIELD_MARKER = 8'h80;
    localparam logic [FIELD_W-1:0] FIELD_ZERO = 8'h00;
    localparam logic [REG_W-1:0] REG_ZERO = 64'h0000_0000_0000_0000;
    localparam logic [2:0] SUBSET_POS_MAX = 3'h6;
    localparam logic [1:0] LEVEL_ZERO = 2'h0;
    localparam logic [1:0] LEVEL_TOP = 2'h3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_COPY = 2'b00,
        MODE_SUBSET = 2'b01,
        MODE_MARK = 2'b10,
        MODE_ZERO = 2'b11
    } pea_mode_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0] wdata;
    } pea_req_type;

    typedef struct packed {
        logic present;
        logic [1:0] level;
        logic subset;
        logic [2:0] subset_pos;
    } pea_cfg_type;

endpackage

`default_nettype wire

/* File: design/pea_field_enc.sv */
`default_nettype none

module pea_field_enc (
    // Selection
    input wire pea_pkg::pea_mode_type mode_i,
    input wire logic [2:0] pos_i,
    // Fields
    input wire logic [pea_pkg::FIELD_W-1:0] id_field_i,
    output logic [pea_pkg::FIELD_W-1:0] field_o
);
    import pea_pkg::*;

    always_comb begin
        field_o = FIELD_ZERO;
        unique case (mode_i)
            MODE_COPY: begin
                field_o = id_field_i;
            end
            MODE_SUBSET: begin
                // Shared bits above the marker bit, a single one at it, zeros below.
                for (int i = 0; i < FIELD_W; i++) begin
                    if (i > int'(pos_i)) begin
                        field_o[i] = id_field_i[i];
                    end else begin
                        field_o[i] = (i == int'(pos_i));
                    end
                end
            end
            MODE_MARK: begin
                field_o = FIELD_MARKER;
            end
            MODE_ZERO: begin
                field_o = FIELD_ZERO;
            end
        endcase
    end

endmodule // pea_field_enc

`default_nettype wire

/* File: design/pea_affinity_reg.sv */
`default_nettype none

module pea_affinity_reg #(
    parameter bit SUBSET_EN = 1'b1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Register port
    input wire pea_pkg::pea_req_type req_i,
    output logic ack_o,
    output logic [pea_pkg::REG_W-1:0] rdata_o,
    // Affinity configuration and element identity
    input wire pea_pkg::pea_cfg_type cfg_i,
    input wire logic [pea_pkg::REG_W-1:0] element_identity_register_i
);
    import pea_pkg::*;

    // ------------------------------------------------------------------
    // Affinity decode
    // ------------------------------------------------------------------
    logic sub_eff;
    logic [2:0] pos_eff;
    logic level_zero_valid_flag;
    pea_mode_type field_mode [NUM_LOW_FIELDS];
    logic [FIELD_W-1:0] field_val [NUM_LOW_FIELDS];
    logic [REG_W-1:0] aff_value;

    always_comb begin
        // Subsets need the newer revision and exist only below level three.
        sub_eff = SUBSET_EN && cfg_i.subset && (cfg_i.level != LEVEL_TOP);
        // The top marker position would collide with the level marker value.
        pos_eff = (cfg_i.subset_pos > SUBSET_POS_MAX) ? SUBSET_POS_MAX : cfg_i.subset_pos;
        level_zero_valid_flag = (cfg_i.level == LEVEL_ZERO) && !sub_eff;
        for (int f = 0; f < NUM_LOW_FIELDS; f++) begin
            if (sub_eff) begin
                if (f > int'(cfg_i.level)) begin
                    field_mode[f] = MODE_COPY;
                end else if (f == int'(cfg_i.level)) begin
                    field_mode[f] = MODE_SUBSET;
                end else begin
                    field_mode[f] = MODE_ZERO;
                end
            end else begin
                if (f >= int'(cfg_i.level)) begin
                    field_mode[f] = MODE_COPY;
                end else if (f == int'(cfg_i.level) - 1) begin
                    field_mode[f] = MODE_MARK;
                end else begin
                    field_mode[f] = MODE_ZERO;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Field encoders
    // ------------------------------------------------------------------
    for (genvar g = 0; g < NUM_LOW_FIELDS; g++) begin : gen_field
        // Fields 0, 1 and 2 are the level-zero, level-one and level-two fields.
        pea_field_enc u_enc (
            .mode_i(field_mode[g]),
            .pos_i(pos_eff),
            .id_field_i(element_identity_register_i[g*FIELD_W +: FIELD_W]),
            .field_o(field_val[g])
        );
    end

    // ------------------------------------------------------------------
    // Register value
    // ------------------------------------------------------------------
    always_comb begin
        aff_value = REG_ZERO;
        if (cfg_i.present) begin
            aff_value[AFFINITY_LEVEL_ZERO_FIELD_LSB +: FIELD_W] = field_val[0];
            aff_value[AFFINITY_LEVEL_ONE_FIELD_LSB +: FIELD_W] = field_val[1];
            aff_value[AFFINITY_LEVEL_TWO_FIELD_LSB +: FIELD_W] = field_val[2];
            aff_value[AFFINITY_LEVEL_THREE_FIELD_LSB +: FIELD_W] =
                element_identity_register_i[AFFINITY_LEVEL_THREE_FIELD_LSB +: FIELD_W];
            aff_value[F0V_BIT] = level_zero_valid_flag;
            // The two flags are undefined for groups; zero is the quietest answer.
            aff_value[U_BIT] =
                level_zero_valid_flag && element_identity_register_i[U_BIT];
            aff_value[MT_BIT] =
                level_zero_valid_flag && element_identity_register_i[MT_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    logic hit;
    logic ack_d;
    logic ack_q;
    logic [REG_W-1:0] rdata_d;
    logic [REG_W-1:0] rdata_q;

    assign hit = req_i.valid && (req_i.addr == AFF_OFFSET);

    always_comb begin
        ack_d = req_i.valid;
        rdata_d = REG_ZERO;
        // Writes and unmapped reads are answered with zero and touch no state.
        if (hit && !req_i.write) begin
            rdata_d = aff_value;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_q <= 1'b0;
            rdata_q <= REG_ZERO;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    assign ack_o = ack_q;
    assign rdata_o = rdata_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    logic rd_hit;
    logic [FIELD_W-1:0] low_mark;
    logic [FIELD_W-1:0] low_mask;
    logic [FIELD_W-1:0] id_sub;
    assign rd_hit = hit && !req_i.write && cfg_i.present;
    assign low_mark = FIELD_W'(8'h01 << pos_eff);
    // The mask covers the marker bit and every bit below it.
    // The identity field of the subset level carries the shared bits.
    assign low_mask = FIELD_W'({low_mark, 1'b0} - 9'h001);
    assign id_sub = element_identity_register_i[cfg_i.level*FIELD_W +: FIELD_W];

    a_resp_one_cycle: assert property (
        req_i.valid |=> ack_o ##1 (ack_o == $past(req_i.valid))
    ) else $error("Register port answer not one cycle after request");

    a_reserved_zero: assert property (
        ack_o |-> (rdata_o[RSVD_HI_LSB +: RSVD_HI_W] == '0)
            && (rdata_o[RSVD_LO_LSB +: RSVD_LO_W] == '0)
    ) else $error("Reserved bits not zero");

    a_absent_zero: assert property (
        (req_i.valid && !cfg_i.present) |=> (rdata_o == REG_ZERO)
    ) else $error("Absent affinity did not read zero");

    a_single_copy: assert property (
        (rd_hit && level_zero_valid_flag) |=> rdata_o[F0V_BIT]
            && (rdata_o[23:0] == $past(element_identity_register_i[23:0]))
            && (rdata_o[U_BIT] == $past(element_identity_register_i[U_BIT]))
    ) else $error("Single element value not copied");

    a_level3_copy: assert property (
        rd_hit |=> rdata_o[AFFINITY_LEVEL_THREE_FIELD_LSB +: FIELD_W]
            == $past(element_identity_register_i[AFFINITY_LEVEL_THREE_FIELD_LSB +: FIELD_W])
    ) else $error("Level three field not copied");

    a_f0v_level: assert property (
        rd_hit |=> rdata_o[F0V_BIT] == ($past(cfg_i.level) == LEVEL_ZERO && !$past(sub_eff))
    ) else $error("Valid flag does not match level");

    a_level1_mark: assert property (
        (rd_hit && cfg_i.level == 2'h1 && !sub_eff)
            |=> rdata_o[AFFINITY_LEVEL_ZERO_FIELD_LSB +: FIELD_W] == FIELD_MARKER
    ) else $error("Level one marker missing");

    a_level3_mark: assert property (
        (rd_hit && cfg_i.level == LEVEL_TOP) |=> (rdata_o[AFFINITY_LEVEL_TWO_FIELD_LSB +: FIELD_W] == FIELD_MARKER)
            && (rdata_o[AFFINITY_LEVEL_ONE_FIELD_LSB +: FIELD_W] == FIELD_ZERO) && !rdata_o[F0V_BIT]
    ) else $error("Level three markers wrong");

    a_subset_l1: assert property (
        (rd_hit && sub_eff && cfg_i.level == 2'h1) |=> (rdata_o[7:0] == FIELD_ZERO)
            && !rdata_o[F0V_BIT] && (rdata_o[15:8] != FIELD_ZERO)
            && (rdata_o[15:8] != FIELD_MARKER)
    ) else $error("Level one subset encoding wrong");

    a_subset_lsb: assert property (
        (rd_hit && sub_eff && cfg_i.level == 2'h2) |=>
            ((rdata_o[23:16] & FIELD_W'(({$past(low_mark), 1'b0}) - 9'h001)) == $past(low_mark))
            && (rdata_o[15:8] == FIELD_ZERO)
    ) else $error("Subset marker bit misplaced");

    a_no_subset: assert property (
        (rd_hit && !SUBSET_EN)
            |=> rdata_o[F0V_BIT] == ($past(cfg_i.level) == LEVEL_ZERO)
    ) else $error("Subset encoding used without support");

    a_write_inert: assert property (
        (req_i.valid && req_i.write) |=> ack_o && (rdata_o == REG_ZERO)
    ) else $error("Write returned data");

    a_level2_mark: assert property (
        (rd_hit && cfg_i.level == 2'h2 && !sub_eff)
            |=> (rdata_o[AFFINITY_LEVEL_ONE_FIELD_LSB +: FIELD_W] == FIELD_MARKER)
            && (rdata_o[AFFINITY_LEVEL_ZERO_FIELD_LSB +: FIELD_W] == FIELD_ZERO)
    ) else $error("Level two marker missing");

    a_level2_group: assert property (
        (rd_hit && cfg_i.level == 2'h2 && !sub_eff) |=> !rdata_o[F0V_BIT]
            && (rdata_o[AFFINITY_LEVEL_TWO_FIELD_LSB +: FIELD_W] == $past(id_sub))
    ) else $error("Level two group fields wrong");

    a_level2_copy: assert property (
        (rd_hit && cfg_i.level != LEVEL_TOP && !(sub_eff && cfg_i.level == 2'h2))
            |=> rdata_o[AFFINITY_LEVEL_TWO_FIELD_LSB +: FIELD_W]
            == $past(element_identity_register_i[AFFINITY_LEVEL_TWO_FIELD_LSB +: FIELD_W])
    ) else $error("Level two field not copied");

    a_level1_copy: assert property (
        (rd_hit && cfg_i.level < 2'h2 && !(sub_eff && cfg_i.level == 2'h1))
            |=> rdata_o[AFFINITY_LEVEL_ONE_FIELD_LSB +: FIELD_W]
            == $past(element_identity_register_i[AFFINITY_LEVEL_ONE_FIELD_LSB +: FIELD_W])
    ) else $error("Level one field not copied");

    a_subset_mark: assert property (
        (rd_hit && sub_eff)
            |=> (rdata_o[$past(cfg_i.level)*FIELD_W +: FIELD_W] & $past(low_mask))
            == $past(low_mark)
    ) else $error("Subset marker not lowest set bit");

    a_subset_shared: assert property (
        (rd_hit && sub_eff)
            |=> (rdata_o[$past(cfg_i.level)*FIELD_W +: FIELD_W] & ~$past(low_mask))
            == ($past(id_sub) & ~$past(low_mask))
    ) else $error("Subset shared bits not copied");

    a_marker_clash: assert property (
        (rd_hit && sub_eff)
            |=> rdata_o[$past(cfg_i.level)*FIELD_W +: FIELD_W] != FIELD_MARKER
    ) else $error("Subset field reads as level marker");

    a_subset_low_zero: assert property (
        (rd_hit && sub_eff && cfg_i.level != LEVEL_ZERO)
            |=> (rdata_o[AFFINITY_LEVEL_ZERO_FIELD_LSB +: FIELD_W] == FIELD_ZERO) && !rdata_o[F0V_BIT]
    ) else $error("Level zero field not cleared for subset");

    a_above_one_zero: assert property (
        (rd_hit && (cfg_i.level > 2'h1 || (sub_eff && cfg_i.level == 2'h1)))
            |=> rdata_o[AFFINITY_LEVEL_ZERO_FIELD_LSB +: FIELD_W] == FIELD_ZERO
    ) else $error("Level zero field not zero above level one");

    a_subset_l0: assert property (
        (rd_hit && sub_eff && cfg_i.level == LEVEL_ZERO)
            |=> !rdata_o[F0V_BIT] && !rdata_o[U_BIT] && !rdata_o[MT_BIT]
    ) else $error("Valid flag set for level zero subset");

    a_mt_copy: assert property (
        (rd_hit && level_zero_valid_flag)
            |=> rdata_o[MT_BIT] == $past(element_identity_register_i[MT_BIT])
    ) else $error("Multithreading flag not copied");

    a_group_flags: assert property (
        (rd_hit && !level_zero_valid_flag) |=> !rdata_o[U_BIT] && !rdata_o[MT_BIT]
    ) else $error("Flags not quiet for a group");

    a_unmapped_zero: assert property (
        (req_i.valid && req_i.addr != AFF_OFFSET) |=> ack_o && (rdata_o == REG_ZERO)
    ) else $error("Unmapped offset returned data");

    a_idle_quiet: assert property (
        !req_i.valid |=> !ack_o && (rdata_o == REG_ZERO)
    ) else $error("Answer without request");

    a_read_value: assert property (
        rd_hit |=> rdata_o == $past(aff_value)
    ) else $error("Read data not the register value");

    a_ack_pulse: assert property (
        (ack_o && !req_i.valid) |=> !ack_o
    ) else $error("Answer stood longer than one cycle");

    c_single_read: cover property (rd_hit && level_zero_valid_flag ##1 ack_o);
    c_subset_read: cover property (rd_hit && sub_eff ##1 ack_o);
    c_level3_read: cover property (rd_hit && cfg_i.level == LEVEL_TOP ##1 ack_o);
    c_write: cover property (hit && req_i.write ##1 ack_o);
    c_absent_read: cover property (req_i.valid && !cfg_i.present ##1 ack_o);

endmodule // pea_affinity_reg

`default_nettype wire

/* File: bench/tb_top.sv */
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pea_pkg::*;

    // ------------------------------------------------------------------
    // Stimulus, clock and the block
    // ------------------------------------------------------------------
    localparam logic [REG_W-1:0] ID_A = 64'hFFFF_FFA5_7FC3_5AB7;
    localparam logic [REG_W-1:0] ID_B = 64'h0000_003C_0096_E14D;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    pea_req_type req_i = '0;
    pea_cfg_type cfg_i = '0;
    logic [REG_W-1:0] ident = ID_A;
    logic ack_o;
    logic [REG_W-1:0] rdata_o;
    logic ack_legacy;
    logic [REG_W-1:0] rdata_legacy;
    int fails = 0;
    int comparisons = 0;

    always #4 clk_i = ~clk_i;

    pea_affinity_reg #(.SUBSET_EN(1'b1)) dut (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .req_i(req_i),
        .ack_o(ack_o),
        .rdata_o(rdata_o),
        .cfg_i(cfg_i),
        .element_identity_register_i(ident)
    );

    // A second copy without the newer revision shares every input.
    pea_affinity_reg #(.SUBSET_EN(1'b0)) dut_legacy (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .req_i(req_i),
        .ack_o(ack_legacy),
        .rdata_o(rdata_legacy),
        .cfg_i(cfg_i),
        .element_identity_register_i(ident)
    );

    // ------------------------------------------------------------------
    // Reference value and shared tasks
    // ------------------------------------------------------------------
    // Identity ID_A sets the reserved positions on purpose, so a leak shows.
    function automatic logic [REG_W-1:0] exp_val(input pea_cfg_type c,
                                                 input logic [REG_W-1:0] id);
        logic [REG_W-1:0] v;
        logic sub;
        int n;
        int p;
        v = '0;
        sub = c.subset && (c.level != 2'h3);
        n = c.level;
        p = (c.subset_pos == 3'h7) ? 6 : c.subset_pos;
        if (!c.present) return v;
        v[39:32] = id[39:32];
        for (int i = 0; i < 3; i++) begin
            if (i > n || (i == n && !sub)) v[8*i+:8] = id[8*i+:8];
            else if (i == n) v[8*i+:8] = (id[8*i+:8] & (8'hff << (p + 1))) | (8'h01 << p);
            else if (i == n - 1 && !sub) v[8*i+:8] = 8'h80;
        end
        if (n == 0 && !sub) begin
            v[31] = 1'b1;
            v[30] = id[30];
            v[24] = id[24];
        end
        return v;
    endfunction

    task automatic check(input string what, input logic [REG_W-1:0] seen,
                         input logic [REG_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One request; the answer stands only in the cycle after the taking edge.
    task automatic do_req(input logic wr, input logic [ADDR_W-1:0] addr,
                          input logic [REG_W-1:0] exp);
        @(posedge clk_i);
        #1;
        check("idle ack", ack_o, 1'b0);
        req_i.valid = 1'b1;
        req_i.write = wr;
        req_i.addr = addr;
        req_i.wdata = ~ident;
        @(posedge clk_i);
        #1;
        req_i.valid = 1'b0;
        check("ack", ack_o, 1'b1);
        check("read data", rdata_o, exp);
    endtask

    task automatic set_cfg(input logic pr, input int lv, input logic sb, input int ps);
        cfg_i.present = pr;
        cfg_i.level = lv[1:0];
        cfg_i.subset = sb;
        cfg_i.subset_pos = ps[2:0];
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_single();
        set_cfg(1'b1, 0, 1'b0, 0);
        ident = ID_A;
        do_req(1'b0, AFF_OFFSET, 64'h0000_00A5_C1C3_5AB7);
        ident = ID_B;
        do_req(1'b0, AFF_OFFSET, exp_val(cfg_i, ident));
        ident = ID_A;
    endtask

    task automatic t_levels();
        for (int n = 1; n < 4; n++) begin
            set_cfg(1'b1, n, 1'b0, 0);
            do_req(1'b0, AFF_OFFSET, exp_val(cfg_i, ident));
        end
        set_cfg(1'b1, 1, 1'b0, 0);
        do_req(1'b0, AFF_OFFSET, 64'h0000_00A5_00C3_5A80);
    endtask

    task automatic t_subsets();
        pea_cfg_type lc;
        for (int lv = 0; lv < 4; lv++) begin
            for (int ps = 0; ps < 8; ps++) begin
                set_cfg(1'b1, lv, 1'b1, ps);
                lc = cfg_i;
                lc.subset = 1'b0;
                do_req(1'b0, AFF_OFFSET, exp_val(cfg_i, ident));
                // The answer still stands; the older revision ignores the subset request.
                check("legacy ack", ack_legacy, 1'b1);
                check("legacy data", rdata_legacy, exp_val(lc, ident));
            end
        end
        set_cfg(1'b1, 1, 1'b1, 2);
        do_req(1'b0, AFF_OFFSET, 64'h0000_00A5_00C3_5C00);
    endtask

    task automatic t_absent();
        for (int lv = 0; lv < 4; lv++) begin
            set_cfg(1'b0, lv, 1'b0, 0);
            do_req(1'b0, AFF_OFFSET, REG_ZERO);
        end
    endtask

    // Writes must be answered yet leave the value as it was.
    task automatic t_write_unmapped();
        set_cfg(1'b1, 0, 1'b0, 0);
        do_req(1'b1, AFF_OFFSET, REG_ZERO);
        do_req(1'b0, AFF_OFFSET, exp_val(cfg_i, ident));
        do_req(1'b0, 12'hfac, REG_ZERO);
        do_req(1'b1, 12'hfac, REG_ZERO);
        do_req(1'b0, AFF_OFFSET, exp_val(cfg_i, ident));
    endtask

    // Two reads with no gap; each answer follows the setting at its own edge.
    task automatic t_b2b();
        logic [REG_W-1:0] first;
        set_cfg(1'b1, 2, 1'b0, 0);
        first = exp_val(cfg_i, ident);
        @(posedge clk_i);
        #1;
        req_i.valid = 1'b1;
        req_i.write = 1'b0;
        req_i.addr = AFF_OFFSET;
        @(posedge clk_i);
        #1;
        set_cfg(1'b1, 0, 1'b1, 5);
        check("b2b first ack", ack_o, 1'b1);
        check("b2b first", rdata_o, first);
        @(posedge clk_i);
        #1;
        req_i.valid = 1'b0;
        check("b2b second ack", ack_o, 1'b1);
        check("b2b second", rdata_o, exp_val(cfg_i, ident));
    endtask

    // A reset in mid-run drops a standing answer at once; the port works after it.
    task automatic t_reset();
        set_cfg(1'b1, 0, 1'b0, 0);
        @(posedge clk_i);
        #1;
        req_i.valid = 1'b1;
        req_i.write = 1'b0;
        req_i.addr = AFF_OFFSET;
        @(posedge clk_i);
        #1;
        req_i.valid = 1'b0;
        check("pre reset ack", ack_o, 1'b1);
        resetn_i = 1'b0;
        #1;
        check("mid reset ack", ack_o, 1'b0);
        check("mid reset data", rdata_o, REG_ZERO);
        repeat (2) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        do_req(1'b0, AFF_OFFSET, exp_val(cfg_i, ident));
    endtask

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("Counts: comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        #1;
        check("reset ack", ack_o, 1'b0);
        check("reset data", rdata_o, REG_ZERO);
        resetn_i = 1'b1;
        t_single();
        t_levels();
        t_subsets();
        t_absent();
        t_write_unmapped();
        t_b2b();
        t_reset();
        report_and_stop();
    end

    // The tests need about 125 cycles; this bound leaves ample margin.
    initial begin
        repeat (5000) @(posedge clk_i);
        fails++;
        report_and_stop();
    end

endmodule // tb_top

`default_nettype wire
